// File: reader_pkg.sv
// constants shared by the host-facing queue, timer and interrupt logic
// assumes a single 40 MHz clock and an active-low asynchronous reset
//==============================================================
package reader_pkg;
    //==========================================================
    // queue geometry
    localparam int QUEUE_DEPTH = 64;
    localparam int BYTE_W      = 8;
    localparam int CNT_W       = 7;
    localparam int WM_W        = 6;
    //==========================================================
    // timer widths and clock rates
    localparam int PRESCALE_W    = 12;
    localparam int COUNTER_W     = 16;
    localparam int MCLK_KHZ      = 40000;
    localparam int TIMER_CLK_KHZ = 6780;
    localparam int DIV_W         = 16;
    //==========================================================
    // interrupt flag positions
    localparam int IRQ_W     = 8;
    localparam int IRQ_TIMER = 0;
    localparam int IRQ_ERR   = 1;
    localparam int IRQ_LOW   = 2;
    localparam int IRQ_HIGH  = 3;
    localparam int IRQ_IDLE  = 4;
    localparam int IRQ_RX    = 5;
    localparam int IRQ_TX    = 6;
    localparam int IRQ_CRC   = 7;
    //==========================================================
    // error status layout
    localparam int ERR_W       = 8;
    localparam int ERR_OVERRUN = 4;
    typedef enum logic {TMR_IDLE, TMR_RUN} timer_state_type;
endpackage

// File: queue_if.sv
// handshake bundle between the queue storage and its user
// assumes both ends share one clock
interface queue_if #(
    parameter int W  = 8,
    parameter int CW = 7
) ();
    logic          wrValid;
    logic          wrReady;
    logic [W-1:0]  wrData;
    logic          rdValid;
    logic          rdReady;
    logic [W-1:0]  rdData;
    logic          flush;
    logic [CW-1:0] count;
    modport fifo_side (input wrValid, wrData, rdReady, flush,
                       output wrReady, rdValid, rdData, count);
    modport user_side (output wrValid, wrData, rdReady, flush,
                       input wrReady, rdValid, rdData, count);
endinterface

// File: tick_divider.sv
// fractional divider making a one-cycle enable at a slower rate
// assumes INC is below MOD so ticks never bunch up
module tick_divider #(
    parameter int INC = 6780,
    parameter int MOD = 40000,
    parameter int W   = 16
) (
    input  wire logic clk,
    input  wire logic rstN,
    output logic      tick
);
    logic [W:0] sum;
    logic [W-1:0] acc_reg;
    //==========================================================
    // phase accumulator, wraps once per output tick
    assign sum = {1'b0, acc_reg} + (W+1)'(INC);
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            acc_reg <= '0;
            tick    <= 1'b0;
        end else if (sum >= (W+1)'(MOD)) begin
            acc_reg <= W'(sum - (W+1)'(MOD));
            tick    <= 1'b1;
        end else begin
            acc_reg <= sum[W-1:0];
            tick    <= 1'b0;
        end
    end
endmodule

// File: queue_fifo.sv
// byte queue storage with flush, fill count and valid/ready sides
// assumes the user never reads and flushes expecting the read data
module queue_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64
) (
    input  wire logic clk,
    input  wire logic rstN,
    queue_if.fifo_side q
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [CW-1:0]    cnt_reg;
    logic             doWr;
    logic             doRd;

    function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction
    //==========================================================
    // handshake terms
    assign q.wrReady = (cnt_reg != CW'(DEPTH));
    assign q.rdValid = (cnt_reg != '0);
    assign q.rdData  = mem[rdPtr_reg];
    assign q.count   = cnt_reg;
    assign doWr = q.wrValid & q.wrReady & ~q.flush;
    assign doRd = q.rdReady & q.rdValid & ~q.flush;
    // storage array, no reset needed
    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_reg] <= q.wrData;
        end
    end
    // pointers and count, flush wins over traffic
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            cnt_reg   <= '0;
        end else if (q.flush) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            cnt_reg   <= '0;
        end else begin
            if (doWr) begin
                wrPtr_reg <= nextPtr(wrPtr_reg);
            end
            if (doRd) begin
                rdPtr_reg <= nextPtr(rdPtr_reg);
            end
            cnt_reg <= CW'(cnt_reg + CW'(doWr) - CW'(doRd));
        end
    end
endmodule

// File: host_fifo_timer_irq.sv
// host-facing queue, reload timer and interrupt flags of the reader
// assumes host and command engine strobes are synchronous to mclk
module host_fifo_timer_irq #(
    parameter int DEPTH = reader_pkg::QUEUE_DEPTH
) (
    input  wire logic                             mclk,
    input  wire logic                             arst_n,
    input  wire logic                             hostWrStb,
    input  wire logic [reader_pkg::BYTE_W-1:0]    hostWrData,
    input  wire logic                             hostRdStb,
    output logic      [reader_pkg::BYTE_W-1:0]    hostRdData,
    input  wire logic                             queueClearBit,
    output logic      [reader_pkg::CNT_W-1:0]     queueByteCount,
    input  wire logic [reader_pkg::WM_W-1:0]      watermarkThreshold,
    output logic                                  almostFullFlag,
    output logic                                  almostEmptyFlag,
    input  wire logic                             smWrValid,
    input  wire logic [reader_pkg::BYTE_W-1:0]    smWrData,
    output logic                                  smWrReady,
    output logic                                  smRdValid,
    output logic      [reader_pkg::BYTE_W-1:0]    smRdData,
    input  wire logic                             smRdReady,
    input  wire logic [reader_pkg::ERR_W-1:0]     uartErrors,
    output logic      [reader_pkg::ERR_W-1:0]     errorStatus,
    input  wire logic [reader_pkg::PRESCALE_W-1:0] prescaleReload,
    input  wire logic [reader_pkg::COUNTER_W-1:0] counterReload,
    output logic      [reader_pkg::COUNTER_W-1:0] counterValue,
    input  wire logic                             timerAutoReload,
    input  wire logic                             timerProtocolAutostart,
    input  wire logic                             protocolStartEvt,
    input  wire logic                             timerManualGo,
    input  wire logic                             timerManualHalt,
    output logic                                  timerActiveStatus,
    input  wire logic                             transmitDoneEvt,
    input  wire logic                             checksumDoneEvt,
    input  wire logic                             receiveDoneEvt,
    input  wire logic                             commandFinishedEvt,
    input  wire logic [reader_pkg::IRQ_W-1:0]     irqEnable,
    input  wire logic [reader_pkg::IRQ_W-1:0]     irqFlagSet,
    input  wire logic [reader_pkg::IRQ_W-1:0]     irqFlagClear,
    output logic      [reader_pkg::IRQ_W-1:0]     irqFlags,
    output logic                                  irqSummary,
    output logic                                  irqPin
);
    localparam logic [reader_pkg::CNT_W-1:0] FULL_CNT =
        reader_pkg::CNT_W'(reader_pkg::QUEUE_DEPTH);

    queue_if #(.W(reader_pkg::BYTE_W), .CW(reader_pkg::CNT_W)) q ();

    logic                               overrun_reg;
    logic                               almostFullNow;
    logic                               almostEmptyNow;
    logic                               timerTick;
    logic                               counterStep;
    logic                               timerStart;
    logic                               timeoutEvt;
    logic                               armed_reg;
    logic [reader_pkg::PRESCALE_W-1:0]  pre_reg;
    logic [reader_pkg::COUNTER_W-1:0]   cnt_reg;
    reader_pkg::timer_state_type        state_reg;
    logic [reader_pkg::IRQ_W-1:0]       events;
    logic [reader_pkg::IRQ_W-1:0]       flags_next;

    //==========================================================
    // queue storage and the timer tick divider
    queue_fifo #(.WIDTH(reader_pkg::BYTE_W), .DEPTH(DEPTH)) u_fifo (
        .clk  (mclk),
        .rstN (arst_n),
        .q    (q)
    );

    tick_divider #(
        .INC (reader_pkg::TIMER_CLK_KHZ),
        .MOD (reader_pkg::MCLK_KHZ),
        .W   (reader_pkg::DIV_W)
    ) u_div (
        .clk  (mclk),
        .rstN (arst_n),
        .tick (timerTick)
    );

    //==========================================================
    // queue port sharing, host strobes take priority
    assign q.wrValid = hostWrStb | smWrValid;
    assign q.wrData  = hostWrStb ? hostWrData : smWrData;
    assign q.rdReady = hostRdStb | smRdReady;
    assign q.flush   = queueClearBit;
    assign smWrReady = q.wrReady & ~hostWrStb & ~queueClearBit;
    assign smRdValid = q.rdValid & ~hostRdStb & ~queueClearBit;
    assign smRdData  = q.rdData;
    assign queueByteCount = q.count;

    // host read data captured from the head byte
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hostRdData <= '0;
        end else if (hostRdStb) begin
            hostRdData <= q.rdValid ? q.rdData : '0;
        end
    end

    // sticky overrun, only the clear bit removes it
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            overrun_reg <= 1'b0;
        end else if (hostWrStb && !q.wrReady) begin
            overrun_reg <= 1'b1;
        end else if (queueClearBit) begin
            overrun_reg <= 1'b0;
        end
    end

    //==========================================================
    // watermark alerts
    assign almostFullNow  = (FULL_CNT - q.count) <=
                            {1'b0, watermarkThreshold};
    assign almostEmptyNow = q.count <= {1'b0, watermarkThreshold};

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            almostFullFlag  <= 1'b0;
            almostEmptyFlag <= 1'b0;
            errorStatus     <= '0;
        end else begin
            almostFullFlag  <= almostFullNow;
            almostEmptyFlag <= almostEmptyNow;
            errorStatus <= uartErrors |
                ({{(reader_pkg::ERR_W-1){1'b0}}, overrun_reg}
                 << reader_pkg::ERR_OVERRUN);
        end
    end

    //==========================================================
    // two-stage timer: prescaler feeds the counter
    assign timerStart  = timerManualGo |
                         (timerProtocolAutostart & protocolStartEvt);
    assign counterStep = (state_reg == reader_pkg::TMR_RUN) &&
                         timerTick && (pre_reg == '0);
    assign timeoutEvt  = counterStep && !armed_reg &&
                         (cnt_reg == 16'h0001);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= reader_pkg::TMR_IDLE;
            pre_reg   <= '0;
            cnt_reg   <= '0;
            armed_reg <= 1'b0;
        end else if (timerManualHalt) begin
            state_reg <= reader_pkg::TMR_IDLE;
        end else if (timerStart) begin
            state_reg <= reader_pkg::TMR_RUN;
            pre_reg   <= prescaleReload;
            cnt_reg   <= counterReload;
            armed_reg <= 1'b1;
        end else if (state_reg == reader_pkg::TMR_RUN && timerTick) begin
            if (pre_reg != '0) begin
                pre_reg <= pre_reg - 1'b1;
            end else begin
                pre_reg <= prescaleReload;
                // first step after a start holds, so a stage lasts reload+1
                if (armed_reg) begin
                    armed_reg <= 1'b0;
                end else if (cnt_reg != '0) begin
                    cnt_reg <= cnt_reg - 1'b1;
                    if (cnt_reg == 16'h0001 && !timerAutoReload) begin
                        state_reg <= reader_pkg::TMR_IDLE;
                    end
                end else if (timerAutoReload) begin
                    cnt_reg <= counterReload;
                end else begin
                    state_reg <= reader_pkg::TMR_IDLE;
                end
            end
        end
    end
    // expiry feeds only the flag below, nothing else reacts to it
    assign counterValue      = cnt_reg;
    assign timerActiveStatus = (state_reg == reader_pkg::TMR_RUN);

    //==========================================================
    // event vector into latched flags
    always_comb begin
        events = '0;
        events[reader_pkg::IRQ_TIMER] = timeoutEvt;
        events[reader_pkg::IRQ_ERR]   = |errorStatus;
        events[reader_pkg::IRQ_LOW]   = almostEmptyNow & ~almostEmptyFlag;
        events[reader_pkg::IRQ_HIGH]  = almostFullNow & ~almostFullFlag;
        events[reader_pkg::IRQ_IDLE]  = commandFinishedEvt;
        events[reader_pkg::IRQ_RX]    = receiveDoneEvt;
        events[reader_pkg::IRQ_TX]    = transmitDoneEvt;
        events[reader_pkg::IRQ_CRC]   = checksumDoneEvt;
    end

    // set beats clear in the same cycle
    assign flags_next = (irqFlags & ~irqFlagClear) | irqFlagSet | events;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irqFlags <= '0;
        end else begin
            irqFlags <= flags_next;
        end
    end

    // summary bit and request pin from enabled flags
    assign irqSummary = |(irqFlags & irqEnable);
    assign irqPin     = irqSummary;

    //==========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence fullWrite;
        hostWrStb && !q.wrReady;
    endsequence

    sequence clearThenIdle;
        queueClearBit ##1 (queueByteCount == '0 && !overrun_reg);
    endsequence

    chk_overrun_set: assert property (
        fullWrite |=> overrun_reg ##1 errorStatus[reader_pkg::ERR_OVERRUN]
    ) else $error("overrun not raised on full write");

    chk_overrun_hold: assert property (
        overrun_reg && !queueClearBit |=> overrun_reg
    ) else $error("overrun dropped without clear");

    chk_flush_empty: assert property (
        queueClearBit && !hostWrStb |-> clearThenIdle
    ) else $error("clear did not empty queue");

    chk_write_count: assert property (
        hostWrStb && q.wrReady && !queueClearBit && !hostRdStb
            && !(smRdReady && q.rdValid)
        |=> queueByteCount == $past(queueByteCount) + 1'b1
    ) else $error("host write did not add one byte");

    chk_read_count: assert property (
        hostRdStb && q.rdValid && !queueClearBit && !q.wrValid
        |=> queueByteCount == $past(queueByteCount) - 1'b1
    ) else $error("host read did not remove one byte");

    chk_alert_latch: assert property (
        almostEmptyNow && !almostEmptyFlag && irqEnable[reader_pkg::IRQ_LOW]
        |=> irqFlags[reader_pkg::IRQ_LOW] && irqPin
    ) else $error("almost empty edge not latched");

    chk_timeout_flag: assert property (
        counterStep && !armed_reg && cnt_reg == 16'h0001 && !timerManualHalt
            && !timerStart
        |=> irqFlags[reader_pkg::IRQ_TIMER] && cnt_reg == '0
    ) else $error("timeout flag missing at zero");

    chk_timer_halt: assert property (
        timerManualHalt |=> !timerActiveStatus
    ) else $error("timer still running after halt");

    chk_error_flag: assert property (
        |errorStatus |=> irqFlags[reader_pkg::IRQ_ERR]
    ) else $error("error flag not set");

    chk_prescale_gap: assert property (
        timerActiveStatus && !timerStart && !timerManualHalt
            && pre_reg != '0
        |=> cnt_reg == $past(cnt_reg)
    ) else $error("counter moved before prescaler expiry");
endmodule

// File: engine_model.sv
// command-engine stand-in on the engine side of the byte queue
// assumes one clock; slow paces both directions to force stalls
module engine_model (
    input  wire logic       clk,
    input  wire logic       rstN,
    input  wire logic       popEn,
    input  wire logic       pushEn,
    input  wire logic       slow,
    input  wire logic [7:0] pushBase,
    input  wire logic       smWrReady,
    input  wire logic       smRdValid,
    input  wire logic [7:0] smRdData,
    output logic            smWrValid,
    output logic      [7:0] smWrData,
    output logic            smRdReady,
    output logic            popSeen,
    output logic      [7:0] popByte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pace_reg;
    logic [7:0] nextByte_reg;
    //==========================================================
    // data lines show the complement while no byte is offered
    assign smWrData = smWrValid ? nextByte_reg : ~nextByte_reg;
    //==========================================================
    // offer and accept bytes, an offer holds until it is taken
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pace_reg     <= 2'h0;
            nextByte_reg <= 8'h00;
            smWrValid    <= 1'b0;
            smRdReady    <= 1'b0;
            popSeen      <= 1'b0;
            popByte      <= 8'h00;
        end else begin
            pace_reg  <= pace_reg + 2'h1;
            popSeen   <= smRdValid && smRdReady;
            popByte   <= smRdData;
            smRdReady <= popEn && (!slow || pace_reg == 2'h3);
            if (smWrValid && smWrReady)
                nextByte_reg <= nextByte_reg + 8'h01;
            else if (!smWrValid && !pushEn)
                nextByte_reg <= pushBase;
            if (!smWrValid || smWrReady)
                smWrValid <= pushEn && (!slow || pace_reg[0]);
        end
    end
endmodule

// File: tb_host_fifo_timer_irq.sv
// self-checking bench for the host queue, timer and interrupt flags
// assumes engine_model serves the command-engine side of the queue
module tb_host_fifo_timer_irq;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEPTH = reader_pkg::QUEUE_DEPTH;
    localparam int LIMIT = 20000;
    logic        mclk, arst_n, hostWrStb, hostRdStb, queueClearBit;
    logic        smWrValid, smWrReady, smRdValid, smRdReady;
    logic        almostFullFlag, almostEmptyFlag, timerActiveStatus;
    logic        timerAutoReload, timerProtocolAutostart, protocolStartEvt;
    logic        timerManualGo, timerManualHalt, irqSummary, irqPin;
    logic        popEn, pushEn, slow, popSeen, ovf, pae, paf, w, r;
    logic [3:0]  evt, tab[3];
    logic [5:0]  watermarkThreshold;
    logic [6:0]  queueByteCount;
    logic [7:0]  hostWrData, hostRdData, smWrData, smRdData, popByte;
    logic [7:0]  uartErrors, errorStatus, irqEnable, irqFlagSet;
    logic [7:0]  irqFlagClear, irqFlags, mflags, pushBase;
    logic [11:0] prescaleReload;
    logic [15:0] counterReload, counterValue;
    logic [7:0]  q[$], got[$];
    int          fail_count, samples_checked, cycles, n, expC;
    //==========================================================
    // design, engine model, clock, timeout and pop collector
    host_fifo_timer_irq i_dut (.mclk, .arst_n, .hostWrStb, .hostWrData,
        .hostRdStb, .hostRdData, .queueClearBit, .queueByteCount,
        .watermarkThreshold, .almostFullFlag, .almostEmptyFlag, .smWrValid,
        .smWrData, .smWrReady, .smRdValid, .smRdData, .smRdReady,
        .uartErrors, .errorStatus, .prescaleReload, .counterReload,
        .counterValue, .timerAutoReload, .timerProtocolAutostart,
        .protocolStartEvt, .timerManualGo, .timerManualHalt,
        .timerActiveStatus, .transmitDoneEvt(evt[2]),
        .checksumDoneEvt(evt[3]), .receiveDoneEvt(evt[1]),
        .commandFinishedEvt(evt[0]), .irqEnable, .irqFlagSet,
        .irqFlagClear, .irqFlags, .irqSummary, .irqPin);
    engine_model i_engine (.clk(mclk), .rstN(arst_n), .popEn, .pushEn,
        .slow, .pushBase, .smWrReady, .smRdValid, .smRdData, .smWrValid,
        .smWrData, .smRdReady, .popSeen, .popByte);
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            give_verdict();
        end
    end
    always @(negedge mclk) if (popSeen === 1'b1) got.push_back(popByte);
    //==========================================================
    // comparison, verdict and stimulus tasks
    task automatic chkWord(input logic [15:0] g, e);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chkByte(input logic [7:0] g, e);
        chkWord({8'h00, g}, {8'h00, e});
    endtask
    task automatic chkBit(input logic g, e);
        chkWord({15'h0000, g}, {15'h0000, e});
    endtask
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic clrFlags;
        @(negedge mclk);
        irqFlagClear = 8'hff;
        @(negedge mclk);
        irqFlagClear = 8'h00;
    endtask
    // new watermark and enables, then a clean interrupt model
    task automatic prime(input logic [5:0] m);
        @(negedge mclk);
        watermarkThreshold = m;
        irqEnable = 8'($urandom);
        repeat (2) @(negedge mclk);
        clrFlags();
        @(negedge mclk);
        mflags = {6'h00, ovf, 1'b0};
        pae = q.size() <= m;
        paf = DEPTH - q.size() <= m;
    endtask
    // one host cycle on the queue, then count, watermark flags, overrun bit, interrupt flags and pin are compared
    task automatic op(input logic wr, rd, cl, input logic [7:0] d);
        logic [7:0] e;
        logic       ae, af;
        e = 8'h00;
        @(negedge mclk);
        {hostWrStb, hostRdStb, queueClearBit, hostWrData} = {wr, rd, cl, d};
        if (cl) begin
            q.delete();
            ovf = 1'b0;
        end else begin
            if (rd && q.size() > 0) e = q.pop_front();
            if (wr && q.size() < DEPTH) q.push_back(d);
            else if (wr) ovf = 1'b1;
        end
        @(negedge mclk);
        {hostWrStb, hostRdStb, queueClearBit} = 3'h0;
        if (rd) chkByte(hostRdData, e);
        repeat (2) @(negedge mclk);
        ae = q.size() <= watermarkThreshold;
        af = DEPTH - q.size() <= watermarkThreshold;
        mflags[1] = mflags[1] | ovf;
        mflags[2] = mflags[2] | (ae & ~pae);
        mflags[3] = mflags[3] | (af & ~paf);
        {pae, paf} = {ae, af};
        chkWord(16'(queueByteCount), 16'(q.size()));
        chkBit(almostEmptyFlag, ae);
        chkBit(almostFullFlag, af);
        chkBit(errorStatus[4], ovf);
        chkByte(irqFlags, mflags);
        chkBit(irqPin, |(mflags & irqEnable));
    endtask
    task automatic waitFlag;
        n = 0;
        while (irqFlags[0] !== 1'b1 && n < 400) begin
            @(negedge mclk);
            n++;
        end
        chkBit(n >= expC - 8 && n <= expC + 8, 1'b1);
        chkWord(counterValue, 16'h0000);
    endtask
    task automatic stopTimer;
        @(negedge mclk);
        timerManualHalt = 1'b1;
        @(negedge mclk);
        timerManualHalt = 1'b0;
        chkBit(timerActiveStatus, 1'b0);
    endtask
    //==========================================================
    // main sequence
    initial begin
        {mclk, arst_n, hostWrStb, hostRdStb, queueClearBit, ovf} = 6'h00;
        {timerAutoReload, timerProtocolAutostart, protocolStartEvt} = 3'h0;
        {timerManualGo, timerManualHalt, popEn, pushEn, slow} = 5'h00;
        {evt, watermarkThreshold, hostWrData, uartErrors} = 26'h0;
        {irqEnable, irqFlagSet, irqFlagClear, pushBase} = 32'h0;
        {prescaleReload, counterReload} = 28'h0;
        tab = '{4'b0100, 4'b1100, 4'b1011};
        void'($urandom(2028));
        repeat (2) @(negedge mclk);
        arst_n = 1'b1;
        repeat (2) @(negedge mclk);
        chkByte(irqFlags, 8'h04);
        chkWord(16'(queueByteCount), 16'h0000);
        // every flag set, bits 0-3 by the host set mask and 4-7 by their events, then cleared by the host
        for (int i = 0; i < 8; i++) begin
            clrFlags();
            irqEnable = i[0] ? ~(8'h01 << i) : (8'h01 << i);
            chkByte(irqFlags, 8'h00);
            if (i >= 4) evt = 4'h1 << (i - 4);
            else irqFlagSet = 8'h01 << i;
            @(negedge mclk);
            {evt, irqFlagSet} = 12'h000;
            @(negedge mclk);
            chkByte(irqFlags, 8'h01 << i);
            chkBit(irqSummary, ~i[0]);
            chkBit(irqPin, ~i[0]);
        end
        for (int b = 0; b < 8; b++) begin
            @(negedge mclk);
            uartErrors = 8'h01 << b;
            irqFlagClear = 8'hff;
            @(negedge mclk);
            irqFlagClear = 8'h00;
            @(negedge mclk);
            chkByte(errorStatus, 8'h01 << b);
            chkBit(irqFlags[1], 1'b1);
            uartErrors = 8'h00;
        end
        // fill past full, drain past empty, flush against a write
        prime(6'($urandom % 62 + 1));
        for (int i = 0; i <= DEPTH; i++) op(1, 0, 0, 8'($urandom));
        for (int i = 0; i <= DEPTH; i++) op(0, 1, 0, 8'h00);
        op(1, 0, 0, 8'h5a);
        op(1, 0, 1, 8'ha5);
        op(0, 1, 0, 8'h00);
        prime(6'($urandom));
        for (int i = 0; i < 60; i++) begin
            w = ($urandom % 3) != 1;
            r = !w || ($urandom % 2 == 1);
            if (q.size() == 0) {w, r} = 2'b10;
            op(w, r, 1'b0, 8'($urandom));
        end
        // host loads eight bytes, engine drains then refills while stalling, host drains the rest
        prime(6'h04);
        for (int i = 0; i < 8; i++) op(1, 0, 0, 8'($urandom));
        got.delete();
        @(negedge mclk);
        {popEn, slow} = 2'b11;
        for (n = 0; got.size() < q.size() && n < 1000; n++) @(negedge mclk);
        popEn = 1'b0;
        while (got.size() > 0) chkByte(got.pop_front(), q.pop_front());
        pushBase = 8'($urandom);
        @(negedge mclk);
        pushEn = 1'b1;
        for (n = 0; queueByteCount < 8 && n < 1000; n++) @(negedge mclk);
        pushEn = 1'b0;
        repeat (4) @(negedge mclk);
        chkBit(queueByteCount >= 8 && queueByteCount <= 9, 1'b1);
        for (int j = 0; j < queueByteCount; j++) q.push_back(pushBase + 8'(j));
        prime(6'h02);
        while (q.size() > 0) op(0, 1, 0, 8'h00);
        // one-shot then auto-reload runs, then start and stop controls
        prescaleReload = 12'($urandom % 4);
        counterReload = 16'($urandom % 4 + 1);
        expC = (prescaleReload + 1) * (counterReload + 1)
               * reader_pkg::MCLK_KHZ / reader_pkg::TIMER_CLK_KHZ;
        clrFlags();
        for (int m = 0; m < 2; m++) begin
            @(negedge mclk);
            timerAutoReload = m[0];
            timerManualGo = 1'b1;
            @(negedge mclk);
            timerManualGo = 1'b0;
            chkBit(timerActiveStatus, 1'b1);
            chkWord(counterValue, counterReload);
            waitFlag();
            clrFlags();
            if (m == 1) waitFlag();
            repeat (3) @(negedge mclk);
            chkBit(timerActiveStatus, m[0]);
            chkWord(16'(queueByteCount), 16'h0000);
        end
        stopTimer();
        for (int t = 0; t < 3; t++) begin
            @(negedge mclk);
            {timerProtocolAutostart, protocolStartEvt} = tab[t][3:2];
            {timerManualGo, timerManualHalt} = tab[t][1:0];
            @(negedge mclk);
            {protocolStartEvt, timerManualGo, timerManualHalt} = 3'h0;
            chkBit(timerActiveStatus, t == 1);
            stopTimer();
        end
        give_verdict();
    end
endmodule
